// File: shared/wdg_pkg.sv
// Package: register map, field layout, reset values and timing counts of the watchdog and dual timers
package wdg_pkg;

   // ***********************************************************
   // Register offsets
   // ***********************************************************
   localparam logic [15:0] WATCHDOG_CONTROL_ADDR = 16'hc00c;
   localparam logic [15:0] TIMER_ZERO_ADDR       = 16'hc010;
   localparam logic [15:0] TIMER_ONE_ADDR        = 16'hc012;
   localparam logic [15:0] IRQ_STATUS_ADDR       = 16'hc0f0;
   localparam logic [15:0] IRQ_MASK_ADDR         = 16'hc0f2;

   // ***********************************************************
   // Watchdog control fields
   // ***********************************************************
   localparam int unsigned WD_RESTART_BIT = 0;
   localparam int unsigned WD_ENABLE_BIT  = 1;
   localparam int unsigned WD_LOCK_BIT    = 2;
   localparam int unsigned WD_PERIOD_LSB  = 3;
   localparam int unsigned WD_FLAG_BIT    = 5;

   // ***********************************************************
   // Interrupt status and mask layout
   // ***********************************************************
   localparam int unsigned IRQ_W          = 3;
   localparam int unsigned IRQ_TIMER_ZERO = 0;
   localparam int unsigned IRQ_TIMER_ONE  = 1;
   localparam int unsigned IRQ_WATCHDOG   = 2;

   // ***********************************************************
   // Reset values
   // ***********************************************************
   localparam logic [15:0]      TIMER_COUNT_RESET = 16'hffff;
   localparam logic [1:0]       WD_PERIOD_RESET   = 2'h0;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET    = 3'h0;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned TICK_NS       = 1000;
   localparam int unsigned TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0]  TICK_LAST     = 4'(TICK_CYCLES - 1);
   // Watchdog periods in ms, counted in microsecond ticks
   localparam real         WD_P0_MS      = 1.4;
   localparam real         WD_P1_MS      = 5.5;
   localparam real         WD_P2_MS      = 22.0;
   localparam real         WD_P3_MS      = 66.0;
   localparam int unsigned WD_P0_TICKS   = int'(WD_P0_MS * 1.0e6 / TICK_NS);
   localparam int unsigned WD_P1_TICKS   = int'(WD_P1_MS * 1.0e6 / TICK_NS);
   localparam int unsigned WD_P2_TICKS   = int'(WD_P2_MS * 1.0e6 / TICK_NS);
   localparam int unsigned WD_P3_TICKS   = int'(WD_P3_MS * 1.0e6 / TICK_NS);
   localparam int unsigned WD_CNT_W      = 17;

endpackage : wdg_pkg

// File: design/wdg_top.sv
// Design: watchdog unit and two microsecond general timers behind a plain register port
`timescale 1ns/1ns

// Notes on behaviour
// - Enabled watchdog expiring without a restart resets the processor.
// - Period field bits 4:3 picks 1.4, 5.5, 22.0 or 66.0 ms.
// - Expiry sets timeout flag bit 5, still readable after processor reset.
// - Timeout flag clears only on external hardware reset.
// - Once lock bit 2 is set, further writes to the watchdog fields are ignored; restart bit 0 still restarts the period.
// - While locked, watchdog always runs regardless of the enable bit.
// - Watchdog counts only while enable bit 1 is one, unless locked.
// - Bit 0 is write-only; writing one restarts the watchdog period.
// - Watchdog timeout can raise a processor interrupt.
// - Each general timer decrements by one every microsecond tick until it reaches zero.
// - A general timer reaching zero raises its interrupt.
// - Writing a timer loads its 16-bit count; count resets to all ones.
// - Clearing a timer's interrupt enable discards its pending interrupt.
module wdg_top #(
   parameter logic [16:0] WD_P0_TICKS = 17'(wdg_pkg::WD_P0_TICKS),
   parameter logic [16:0] WD_P1_TICKS = 17'(wdg_pkg::WD_P1_TICKS),
   parameter logic [16:0] WD_P2_TICKS = 17'(wdg_pkg::WD_P2_TICKS),
   parameter logic [16:0] WD_P3_TICKS = 17'(wdg_pkg::WD_P3_TICKS)
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Register port
   input  wire logic [15:0] addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr_stb,
   input  wire logic        rd_stb,
   output logic      [15:0] rdata,
   // Processor side
   output logic             cpu_reset,
   output logic             irq,
   output logic             general_timer_zero_irq,
   output logic             general_timer_one_irq
);

   // ***********************************************************
   // Declarations
   // ***********************************************************
   logic [3:0]                     presc_ff;
   logic                           us_tick;
   logic                           wr_wd;
   logic                           wr_stat;
   logic                           wr_mask;
   logic [1:0]                     wr_tm;
   logic                           lock_ff;
   logic                           watchdog_run_enable_ff;
   logic [1:0]                     period_ff;
   logic                           flag_ff;
   logic                           wd_run;
   logic [wdg_pkg::WD_CNT_W-1:0]   wd_cnt_ff;
   logic [wdg_pkg::WD_CNT_W-1:0]   nxt_wd_cnt;
   logic [wdg_pkg::WD_CNT_W-1:0]   wd_limit;
   logic                           wd_expire;
   logic                           cpu_reset_ff;
   logic [15:0]                    tm_cnt_ff [2];
   logic [1:0]                     tm_zero_evt;
   logic [wdg_pkg::IRQ_W-1:0]      stat_ff;
   logic [wdg_pkg::IRQ_W-1:0]      mask_ff;
   logic [wdg_pkg::IRQ_W-1:0]      evt;
   logic [15:0]                    rdata_ff;
   logic [15:0]                    nxt_rdata;

   // ***********************************************************
   // Address decode
   // ***********************************************************
   // Writes only; reads are decoded in the read mux
   assign wr_wd   = wr_stb && (addr == wdg_pkg::WATCHDOG_CONTROL_ADDR);
   assign wr_tm   = {wr_stb && (addr == wdg_pkg::TIMER_ONE_ADDR), wr_stb && (addr == wdg_pkg::TIMER_ZERO_ADDR)};
   assign wr_stat = wr_stb && (addr == wdg_pkg::IRQ_STATUS_ADDR);
   assign wr_mask = wr_stb && (addr == wdg_pkg::IRQ_MASK_ADDR);

   // ***********************************************************
   // Microsecond prescaler
   // ***********************************************************
   // Free-running divider; shared by timers and watchdog so both see one time base
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         presc_ff <= 4'h0;
      else if (presc_ff == wdg_pkg::TICK_LAST)
         presc_ff <= 4'h0;
      else
         presc_ff <= presc_ff + 4'h1;
   end

   assign us_tick = (presc_ff == wdg_pkg::TICK_LAST);

   // ***********************************************************
   // Watchdog control register
   // ***********************************************************
   // Lock latches until external reset, freezing the other fields
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         lock_ff                <= 1'b0;
         watchdog_run_enable_ff <= 1'b0;
         period_ff              <= wdg_pkg::WD_PERIOD_RESET;
      end
      else if (wr_wd && !lock_ff)
      begin
         lock_ff                <= wdata[wdg_pkg::WD_LOCK_BIT];
         watchdog_run_enable_ff <= wdata[wdg_pkg::WD_ENABLE_BIT];
         period_ff              <= wdata[wdg_pkg::WD_PERIOD_LSB +: 2];
      end
   end

   // Lock overrides the enable bit
   assign wd_run = watchdog_run_enable_ff || lock_ff;

   // Period table in ticks
   always_comb
   begin
      unique case (period_ff)
         2'h0: wd_limit = WD_P0_TICKS;
         2'h1: wd_limit = WD_P1_TICKS;
         2'h2: wd_limit = WD_P2_TICKS;
         2'h3: wd_limit = WD_P3_TICKS;
      endcase
   end

   // ***********************************************************
   // Watchdog counter
   // ***********************************************************
   // Expiry on the tick that completes the period
   assign wd_expire = wd_run && us_tick && (wd_cnt_ff == wd_limit - 17'h1);

   // Restart strobe is honoured even under lock, otherwise a locked dog could never be kept alive
   always_comb
   begin
      if (!wd_run)
         nxt_wd_cnt = '0;
      else if (wr_wd && wdata[wdg_pkg::WD_RESTART_BIT])
         nxt_wd_cnt = '0;
      else if (wd_expire)
         nxt_wd_cnt = '0;
      else if (us_tick)
         nxt_wd_cnt = wd_cnt_ff + 17'h1;
      else
         nxt_wd_cnt = wd_cnt_ff;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         wd_cnt_ff <= '0;
      else
         wd_cnt_ff <= nxt_wd_cnt;
   end

   // Processor reset pulse, one cycle per expiry
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         cpu_reset_ff <= 1'b0;
      else
         cpu_reset_ff <= wd_expire;
   end

   // Timeout flag ignores writes; only external reset clears it
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         flag_ff <= 1'b0;
      else if (wd_expire)
         flag_ff <= 1'b1;
   end

   // ***********************************************************
   // General timers
   // ***********************************************************
   // Count holds at zero so a single interrupt is raised per load
   for (genvar i = 0; i < 2; i++)
   begin : g_tm
      always_ff @(posedge clock)
      begin
         if (!rst_n)
            tm_cnt_ff[i] <= wdg_pkg::TIMER_COUNT_RESET;
         else if (wr_tm[i])
            tm_cnt_ff[i] <= wdata;
         else if (us_tick && (tm_cnt_ff[i] != 16'h0))
            tm_cnt_ff[i] <= tm_cnt_ff[i] - 16'h1;
      end

      assign tm_zero_evt[i] = !wr_tm[i] && us_tick && (tm_cnt_ff[i] == 16'h1);
   end

   // ***********************************************************
   // Interrupt status and mask
   // ***********************************************************
   assign evt = {wd_expire, tm_zero_evt};

   // Sticky status, write one to clear; a new event beats the clear
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         stat_ff <= '0;
      else
      begin
         for (int b = 0; b < wdg_pkg::IRQ_W; b++)
         begin
            if (evt[b])
               stat_ff[b] <= 1'b1;
            else if (wr_stat && wdata[b])
               stat_ff[b] <= 1'b0;
            else if (wr_mask && !wdata[b] && (b != wdg_pkg::IRQ_WATCHDOG))
               stat_ff[b] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         mask_ff <= wdg_pkg::IRQ_MASK_RESET;
      else if (wr_mask)
         mask_ff <= wdata[wdg_pkg::IRQ_W-1:0];
   end

   // ***********************************************************
   // Read path
   // ***********************************************************
   // Restart bit is write-only and reads as zero
   always_comb
   begin
      nxt_rdata = 16'h0;
      unique case (addr)
         wdg_pkg::WATCHDOG_CONTROL_ADDR:
         begin
            nxt_rdata[wdg_pkg::WD_ENABLE_BIT]      = watchdog_run_enable_ff;
            nxt_rdata[wdg_pkg::WD_LOCK_BIT]        = lock_ff;
            nxt_rdata[wdg_pkg::WD_PERIOD_LSB +: 2] = period_ff;
            nxt_rdata[wdg_pkg::WD_FLAG_BIT]        = flag_ff;
         end
         wdg_pkg::TIMER_ZERO_ADDR: nxt_rdata = tm_cnt_ff[0];
         wdg_pkg::TIMER_ONE_ADDR:  nxt_rdata = tm_cnt_ff[1];
         wdg_pkg::IRQ_STATUS_ADDR: nxt_rdata[wdg_pkg::IRQ_W-1:0] = stat_ff;
         wdg_pkg::IRQ_MASK_ADDR:   nxt_rdata[wdg_pkg::IRQ_W-1:0] = mask_ff;
         default:                  nxt_rdata = 16'h0;
      endcase
   end

   // Data stand only in the cycle after the strobe
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         rdata_ff <= 16'h0;
      else if (rd_stb)
         rdata_ff <= nxt_rdata;
      else
         rdata_ff <= 16'h0;
   end

   // ***********************************************************
   // Outputs
   // ***********************************************************
   assign rdata                  = rdata_ff;
   assign cpu_reset              = cpu_reset_ff;
   assign irq                    = |(stat_ff & mask_ff);
   assign general_timer_zero_irq = stat_ff[wdg_pkg::IRQ_TIMER_ZERO] && mask_ff[wdg_pkg::IRQ_TIMER_ZERO];
   assign general_timer_one_irq  = stat_ff[wdg_pkg::IRQ_TIMER_ONE] && mask_ff[wdg_pkg::IRQ_TIMER_ONE];

   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   sequence tick_gap_s;
      us_tick ##1 !us_tick [*8] ##1 !us_tick ##1 us_tick;
   endsequence

   sequence tm0_last_tick_s;
      us_tick && (tm_cnt_ff[0] == 16'h1) && !wr_tm[0];
   endsequence

   expire_reset_a: assert property (wd_expire |=> cpu_reset && flag_ff && (wd_cnt_ff == '0))
      else $error("Watchdog expiry did not reset processor");
   period_limit_a: assert property (wd_expire |-> wd_cnt_ff == wd_limit - 17'h1)
      else $error("Watchdog expired at wrong count");
   flag_visible_a: assert property (cpu_reset |-> flag_ff)
      else $error("Timeout flag not set during processor reset");
   flag_sticky_a: assert property (flag_ff |=> flag_ff)
      else $error("Timeout flag cleared without hardware reset");
   lock_freeze_a: assert property (lock_ff && wr_wd |=> $stable(period_ff) && $stable(watchdog_run_enable_ff))
      else $error("Locked watchdog register changed");
   lock_run_a: assert property (lock_ff |-> wd_run ##1 lock_ff)
      else $error("Locked watchdog stopped");
   disabled_idle_a: assert property (!wd_run |=> (wd_cnt_ff == '0) && !cpu_reset)
      else $error("Disabled watchdog counted");
   restart_count_a: assert property (wd_run && wr_wd && wdata[wdg_pkg::WD_RESTART_BIT] |=> wd_cnt_ff == '0)
      else $error("Restart strobe did not restart count");
   wd_irq_a: assert property (wd_expire |=> stat_ff[wdg_pkg::IRQ_WATCHDOG])
      else $error("Watchdog expiry did not set status");
   timer_dec_a: assert property (us_tick && !wr_tm[1] && tm_cnt_ff[1] != 16'h0 |=> tm_cnt_ff[1] == $past(tm_cnt_ff[1]) - 16'h1)
      else $error("Timer did not decrement on tick");
   timer_irq_a: assert property (tm0_last_tick_s |=> (tm_cnt_ff[0] == 16'h0) && stat_ff[wdg_pkg::IRQ_TIMER_ZERO])
      else $error("Timer zero did not raise status");
   timer_load_a: assert property (wr_tm[0] |=> tm_cnt_ff[0] == $past(wdata))
      else $error("Timer write did not load count");
   mask_discard_a: assert property (wr_mask && !wdata[0] && !evt[0] |=> !stat_ff[0] && !general_timer_zero_irq)
      else $error("Pending timer interrupt kept after disable");
   tick_period_a: assert property (us_tick |-> tick_gap_s)
      else $error("Microsecond tick spacing wrong");

endmodule : wdg_top

// File: tb/test_watchdog_and_dual_timers.sv
// Testbench: self-checking bench for the watchdog unit and the two general timers
`timescale 1ns/1ns

module test_watchdog_and_dual_timers;

   // ***********************************************************
   // Stimulus, responses and bookkeeping
   // ***********************************************************
   logic        clock  = 1'b0;
   logic        rst_n  = 1'b0;
   logic [15:0] addr   = 16'h0000;
   logic [15:0] wdata  = 16'h0000;
   logic        wr_stb = 1'b0;
   logic        rd_stb = 1'b0;
   logic [15:0] rdata;
   logic        cpu_reset;
   logic        irq;
   logic        general_timer_zero_irq;
   logic        general_timer_one_irq;
   int          mismatches = 0;
   int          n_compared = 0;
   int          n_resets   = 0;
   int          seed;
   int          wd_ticks [4] = '{4, 5, 6, 7};

   // Short watchdog periods keep the run brief; expectations use the same table
   wdg_top #(.WD_P0_TICKS(17'h4), .WD_P1_TICKS(17'h5), .WD_P2_TICKS(17'h6), .WD_P3_TICKS(17'h7)) wdg_top_i (
      .clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .cpu_reset(cpu_reset), .irq(irq),
      .general_timer_zero_irq(general_timer_zero_irq), .general_timer_one_irq(general_timer_one_irq));

   // 10 MHz clock
   always #50 clock = ~clock;

   // Count processor reset pulses, so silent stretches can be judged
   always @(posedge clock)
      if (cpu_reset === 1'b1)
         n_resets <= n_resets + 1;

   // ***********************************************************
   // Tasks and functions
   // ***********************************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         mismatches++;
         $display("Error at %0t ns: seen %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : conclude

   // One-cycle write; strobe drops at the edge that takes it
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge clock);
      wr_stb <= 1'b0;
      // Let the write settle, so a compare right after the call sees its effect
      #1;
   endtask : wr

   // One-cycle read; data is looked at only in the cycle after the strobe
   task automatic rd(input logic [15:0] a, output logic [15:0] d);
      @(posedge clock);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge clock);
      rd_stb <= 1'b0;
      #1;
      d = rdata;
   endtask : rd

   task automatic hw_reset;
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
   endtask : hw_reset

   // Bounded wait for cpu_reset (0) or a timer interrupt (1, 2)
   task automatic wait_for(input int which, input int limit, output int cycles);
      logic seen;
      cycles = 0;
      seen   = 1'b0;
      while (!seen)
      begin
         @(posedge clock);
         #1;
         cycles++;
         case (which)
            0:       seen = (cpu_reset === 1'b1);
            1:       seen = (general_timer_zero_irq === 1'b1);
            default: seen = (general_timer_one_irq === 1'b1);
         endcase
         if (cycles > limit)
         begin
            check(16'h0000, 16'h0001);
            conclude();
         end
      end
   endtask : wait_for

   // Tick phase is unknown, so an event after n ticks lands in a ten-cycle window
   function automatic logic [15:0] in_window(input int cycles, input int ticks);
      return 16'((cycles >= (ticks - 1) * wdg_pkg::TICK_CYCLES + 1) && (cycles <= ticks * wdg_pkg::TICK_CYCLES));
   endfunction : in_window

   // ***********************************************************
   // Main sequence
   // ***********************************************************
   initial
   begin
      logic [15:0] v;
      logic [15:0] r;
      logic [15:0] ta;
      int          c;
      int          n;
      int          base;
      seed = 82;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      // Reset values and an unmapped place
      rd(wdg_pkg::TIMER_ZERO_ADDR, v); check(v, 16'hffff);
      rd(wdg_pkg::TIMER_ONE_ADDR, v); check(v, 16'hffff);
      rd(wdg_pkg::WATCHDOG_CONTROL_ADDR, v); check(v, 16'h0000);
      rd(wdg_pkg::IRQ_MASK_ADDR, v); check(v, 16'h0000);
      rd(wdg_pkg::IRQ_STATUS_ADDR, v); check(v, 16'h0000);
      wr(16'hc014, 16'h1234);
      rd(16'hc014, v); check(v, 16'h0000);
      // Large random load reads back, at most one tick lower
      r = 16'h8000 | 16'($random(seed));
      wr(wdg_pkg::TIMER_ONE_ADDR, r);
      rd(wdg_pkg::TIMER_ONE_ADDR, v); check(16'(v === r || v === r - 16'h1), 16'h0001);
      // Each timer runs down from a random small count and interrupts at zero
      wr(wdg_pkg::IRQ_MASK_ADDR, 16'h0007);
      for (int t = 0; t < 2; t++)
      begin
         n  = 2 + ($unsigned($random(seed)) % 6);
         ta = t ? wdg_pkg::TIMER_ONE_ADDR : wdg_pkg::TIMER_ZERO_ADDR;
         wr(ta, 16'(n));
         wait_for(t + 1, 100, c);
         check(in_window(c, n), 16'h0001);
         check(16'(irq), 16'h0001);
         rd(ta, v); check(v, 16'h0000);
         rd(wdg_pkg::IRQ_STATUS_ADDR, v); check(v, 16'(1 << t));
         wr(wdg_pkg::IRQ_STATUS_ADDR, 16'(1 << t));
         check(16'(irq), 16'h0000);
      end
      // Clearing the enable drops a pending timer interrupt
      wr(wdg_pkg::TIMER_ZERO_ADDR, 16'h0002);
      wait_for(1, 100, c);
      wr(wdg_pkg::IRQ_MASK_ADDR, 16'h0006);
      wr(wdg_pkg::IRQ_MASK_ADDR, 16'h0007);
      check(16'(general_timer_zero_irq), 16'h0000);
      rd(wdg_pkg::IRQ_STATUS_ADDR, v); check(v, 16'h0000);
      // Every period code, measured to the processor reset pulse
      for (int p = 0; p < 4; p++)
      begin
         wr(wdg_pkg::WATCHDOG_CONTROL_ADDR, 16'(16'h0002 | (p << 3)));
         wait_for(0, 100, c);
         check(in_window(c, wd_ticks[p]), 16'h0001);
         check(16'(irq), 16'h0001);
         rd(wdg_pkg::WATCHDOG_CONTROL_ADDR, v); check(v, 16'(16'h0022 | (p << 3)));
         wr(wdg_pkg::WATCHDOG_CONTROL_ADDR, 16'h0000);
         wr(wdg_pkg::IRQ_STATUS_ADDR, 16'h0004);
         check(16'(irq), 16'h0000);
      end
      // Disabled watchdog stays quiet
      base = n_resets;
      repeat (100) @(posedge clock);
      check(16'(n_resets - base), 16'h0000);
      // Restarts at random spacing inside the longest period prevent expiry
      wr(wdg_pkg::WATCHDOG_CONTROL_ADDR, 16'h001a);
      base = n_resets;
      for (int k = 0; k < 6; k++)
      begin
         repeat (20 + $unsigned($random(seed)) % 35) @(posedge clock);
         wr(wdg_pkg::WATCHDOG_CONTROL_ADDR, 16'h001b);
      end
      check(16'(n_resets - base), 16'h0000);
      wr(wdg_pkg::WATCHDOG_CONTROL_ADDR, 16'h0000);
      // Locked watchdog ignores an attempt to stop it and still fires
      wr(wdg_pkg::WATCHDOG_CONTROL_ADDR, 16'h0006);
      wr(wdg_pkg::WATCHDOG_CONTROL_ADDR, 16'h0018);
      rd(wdg_pkg::WATCHDOG_CONTROL_ADDR, v); check(v, 16'h0026);
      wait_for(0, 41, c);
      // Expiry counted from the lock write, four cycles before the wait began
      check(in_window(c + 4, wd_ticks[0]), 16'h0001);
      // Own reset pulse leaves the flag; only the hardware reset clears it and the lock
      rd(wdg_pkg::WATCHDOG_CONTROL_ADDR, v); check(v, 16'h0026);
      hw_reset();
      rd(wdg_pkg::WATCHDOG_CONTROL_ADDR, v); check(v, 16'h0000);
      base = n_resets;
      repeat (100) @(posedge clock);
      check(16'(n_resets - base), 16'h0000);
      conclude();
   end

endmodule : test_watchdog_and_dual_timers
